// File: core/rst_seq_pkg.sv
/*
 * constants and carrier types for the reset cause and release sequencer.
 * assumes a 100 MHz core clock; delay counts derive from that rate.
 */
`default_nettype none
package rst_seq_pkg;
	localparam int CLK_MHZ             = 100;
	localparam int BIAS_SETTLE_US      = 10;
	localparam int MON_SETTLE_US       = 100;
	localparam int PWRUP_4_MS          = 4;
	localparam int PWRUP_16_MS         = 16;
	localparam int PWRUP_64_MS         = 64;
	localparam int BIAS_SETTLE_CYC     = BIAS_SETTLE_US * CLK_MHZ;
	localparam int MON_SETTLE_CYC      = MON_SETTLE_US * CLK_MHZ;
	localparam int PWRUP_4_CYC         = PWRUP_4_MS * 1000 * CLK_MHZ;
	localparam int PWRUP_16_CYC        = PWRUP_16_MS * 1000 * CLK_MHZ;
	localparam int PWRUP_64_CYC        = PWRUP_64_MS * 1000 * CLK_MHZ;
	localparam int CNT_W               = 24;
	localparam logic [23:0] VEC_RESET  = 24'h000000;
	localparam logic [23:0] VEC_TRAP   = 24'h000004;
	localparam logic [23:0] PC_STEP    = 24'h000002;
	// power-up delay fuse encodings
	localparam logic [1:0] PWRUP_NONE  = 2'h0;
	localparam logic [1:0] PWRUP_4     = 2'h1;
	localparam logic [1:0] PWRUP_16    = 2'h2;
	localparam logic [1:0] PWRUP_64    = 2'h3;
	// brown-out trip level encodings; 2'h3 is not valid
	localparam logic [1:0] BO_LVL_LOW  = 2'h0;
	localparam logic [1:0] BO_LVL_MID  = 2'h1;
	localparam logic [1:0] BO_LVL_HIGH = 2'h2;
	// oscillator group fuse value meaning the fast internal osc
	localparam logic [1:0] OSC_GRP_FAST_INT = 2'h2;
	localparam int OSC_LOCK_BIT        = 5;

	typedef struct packed {
		logic trap_conflict;
		logic illegal_op;
		logic pin_reset;
		logic software_reset;
		logic watchdog_timeout;
		logic idle;
		logic sleep;
		// brownout must sit at bit 1 of the cause word
		logic brownout;
		logic power_on;
	} cause_flags_t;

	localparam cause_flags_t FLAGS_RST = '0;

	typedef struct packed {
		logic [1:0] osc_group_fuse;
		logic [3:0] primary_osc_fuse;
		logic [1:0] power_up_timer;
		logic [1:0] bo_level;
		logic       clock_fail_monitor;
		logic       crystal_mode;
		logic       pll_used;
	} cfg_fuses_t;
endpackage
`default_nettype wire

// File: core/reset_cause_and_release_sequencer.sv
/*
 * reset release sequencing, reset cause flags and vector selection.
 * assumes reset sources are one-cycle pulses synchronous to core_clk,
 * and that oscillator status and fuses are stable levels on this clock.
 */
`timescale 1ns/1ps
`default_nettype none
module reset_cause_and_release_sequencer
	import rst_seq_pkg::*;
#(
	parameter int BIAS_CYC  = BIAS_SETTLE_CYC,
	parameter int MON_CYC   = MON_SETTLE_CYC,
	parameter int PWR4_CYC  = PWRUP_4_CYC,
	parameter int PWR16_CYC = PWRUP_16_CYC,
	parameter int PWR64_CYC = PWRUP_64_CYC
) (
	input  wire logic                      core_clk,
	input  wire logic                      sys_rst,
	input  wire rst_seq_pkg::cfg_fuses_t   cfg,
	input  wire logic                      power_on_evt,
	input  wire logic                      brownout_trip,
	input  wire logic                      brownout_en,
	input  wire logic                      master_clear_pin,
	input  wire logic                      sw_reset_evt,
	input  wire logic                      watchdog_timeout,
	input  wire logic                      trap_conflict_evt,
	input  wire logic                      illegal_op_evt,
	input  wire logic                      irq_wake,
	input  wire logic [23:0]               irq_vector,
	input  wire logic [23:0]               cur_pc,
	input  wire logic                      in_sleep,
	input  wire logic                      in_idle,
	input  wire logic                      osc_running,
	input  wire logic                      osc_startup_timer_done,
	input  wire logic [15:0]               osc_control_reg,
	input  wire logic                      first_quarter_phase,
	input  wire logic                      flags_wr,
	input  wire rst_seq_pkg::cause_flags_t flags_wdata,
	output logic                           internal_system_reset,
	output logic                           clk_fail_trap,
	output logic                           sel_fast_internal_osc,
	output logic [1:0]                     osc_group_sel,
	output logic                           pc_load,
	output logic [23:0]                    pc_value,
	output rst_seq_pkg::cause_flags_t      reset_cause_reg,
	output logic                           bo_level_bad
);
	import rst_seq_pkg::*;

	typedef enum {ST_RUN, ST_DELAY, ST_CLKWAIT, ST_QWAIT} seq_state_t;

	seq_state_t        state_ff;
	logic [CNT_W-1:0]  bias_cnt_ff;
	logic [CNT_W-1:0]  pwr_cnt_ff;
	logic              delay_run_ff;
	logic              trap_vec_ff;
	logic [CNT_W-1:0]  pwr_load;
	logic              bo_evt;
	logic              clk_ready;
	logic              any_reset;
	logic              delays_done;

	// brown-out detection is not gated by sleep or idle
	assign bo_evt = brownout_en & brownout_trip;
	assign any_reset = power_on_evt | bo_evt | master_clear_pin |
		sw_reset_evt | watchdog_timeout & ~in_sleep | trap_conflict_evt |
		illegal_op_evt;
	// crystal needs its start-up timer, pll needs lock
	assign clk_ready = osc_running &
		(~cfg.crystal_mode | osc_startup_timer_done) &
		(~cfg.pll_used | osc_control_reg[OSC_LOCK_BIT]);
	assign delays_done = bias_cnt_ff == '0 && pwr_cnt_ff == '0;

	always_comb begin
		case (cfg.power_up_timer)
		PWRUP_4:  pwr_load = CNT_W'(PWR4_CYC);
		PWRUP_16: pwr_load = CNT_W'(PWR16_CYC);
		PWRUP_64: pwr_load = CNT_W'(PWR64_CYC);
		// zero delay with a crystal still lets the monitor settle
		default:  pwr_load = cfg.crystal_mode ? CNT_W'(MON_CYC) : '0;
		endcase
	end

	// delay counters run beside clock start-up, not after it
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			bias_cnt_ff <= '0;
			pwr_cnt_ff  <= '0;
		end else if (power_on_evt | bo_evt) begin
			bias_cnt_ff <= CNT_W'(BIAS_CYC);
			pwr_cnt_ff  <= pwr_load;
		end else begin
			// power-up delay starts only once the bias delay is over
			if (bias_cnt_ff != '0)
				bias_cnt_ff <= bias_cnt_ff - 1'b1;
			else if (pwr_cnt_ff != '0)
				pwr_cnt_ff <= pwr_cnt_ff - 1'b1;
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			state_ff <= ST_DELAY;
			delay_run_ff <= 1'b0;
		end else if (any_reset) begin
			state_ff <= ST_DELAY;
			delay_run_ff <= power_on_evt | bo_evt;
		end else begin
			case (state_ff)
			ST_DELAY: begin
				if (!delay_run_ff || delays_done) begin
					if (cfg.clock_fail_monitor || clk_ready)
						state_ff <= ST_QWAIT;
					else
						state_ff <= ST_CLKWAIT;
				end
			end
			ST_CLKWAIT: begin
				if (clk_ready)
					state_ff <= ST_QWAIT;
			end
			ST_QWAIT: begin
				if (first_quarter_phase)
					state_ff <= ST_RUN;
			end
			ST_RUN: state_ff <= ST_RUN;
			default: state_ff <= ST_DELAY;
			endcase
		end
	end

	// the reset output is a flop decoded ahead of state, so it drops on the same edge that state enters ST_RUN
	always_ff @(posedge core_clk) begin
		if (sys_rst)
			internal_system_reset <= 1'b1;
		else
			internal_system_reset <= any_reset ||
				!(state_ff == ST_QWAIT && first_quarter_phase ||
				state_ff == ST_RUN);
	end

	// trap decision taken when the delays end with the monitor on
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			trap_vec_ff <= 1'b0;
			clk_fail_trap <= 1'b0;
			sel_fast_internal_osc <= 1'b0;
		end else begin
			clk_fail_trap <= 1'b0;
			if (any_reset) begin
				trap_vec_ff <= 1'b0;
				if (power_on_evt | bo_evt)
					sel_fast_internal_osc <= 1'b0;
			end else if (state_ff == ST_DELAY && (!delay_run_ff || delays_done)
				&& cfg.clock_fail_monitor && !clk_ready) begin
				trap_vec_ff <= 1'b1;
				sel_fast_internal_osc <= 1'b1;
			end else if (state_ff == ST_QWAIT && first_quarter_phase
				&& trap_vec_ff) begin
				clk_fail_trap <= 1'b1;
			end
		end
	end

	// clock source reselected from fuses on power-on and brown-out
	always_ff @(posedge core_clk) begin
		if (sys_rst)
			osc_group_sel <= 2'h0;
		else if (power_on_evt | bo_evt)
			osc_group_sel <= cfg.osc_group_fuse;
		else if (state_ff == ST_DELAY && (!delay_run_ff || delays_done)
			&& cfg.clock_fail_monitor && !clk_ready)
			osc_group_sel <= OSC_GRP_FAST_INT;
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst)
			bo_level_bad <= 1'b0;
		else
			bo_level_bad <= cfg.bo_level != BO_LVL_LOW &&
				cfg.bo_level != BO_LVL_MID &&
				cfg.bo_level != BO_LVL_HIGH;
	end

	// vector selection; wake-ups load at once, resets at release
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			pc_load  <= 1'b0;
			pc_value <= VEC_RESET;
		end else begin
			pc_load <= 1'b0;
			if (state_ff == ST_QWAIT && first_quarter_phase && !any_reset) begin
				pc_load  <= 1'b1;
				pc_value <= trap_vec_ff ? VEC_TRAP : VEC_RESET;
			end else if (!any_reset && watchdog_timeout && in_sleep) begin
				pc_load  <= 1'b1;
				pc_value <= cur_pc + PC_STEP;
			end else if (!any_reset && irq_wake && in_sleep) begin
				pc_load  <= 1'b1;
				pc_value <= irq_vector;
			end
		end
	end

	// hardware events are applied after the software write so they win
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			reset_cause_reg <= FLAGS_RST;
		end else begin
			cause_flags_t f;
			f = flags_wr ? flags_wdata : reset_cause_reg;
			if (power_on_evt) begin
				f = FLAGS_RST;
				f.power_on = 1'b1;
				f.brownout = 1'b1;
			end else if (bo_evt) begin
				f.brownout = 1'b1;
				f.power_on = 1'b0;
			end else begin
				if (master_clear_pin) begin
					f.pin_reset = 1'b1;
					f.software_reset = 1'b0;
					f.watchdog_timeout = 1'b0;
					f.sleep = in_sleep;
					f.idle = in_idle;
				end else if (sw_reset_evt) begin
					f.software_reset = 1'b1;
					f.pin_reset = 1'b0;
					f.watchdog_timeout = 1'b0;
					f.idle = 1'b0;
					f.sleep = 1'b0;
				end else if (watchdog_timeout && !in_sleep) begin
					f.watchdog_timeout = 1'b1;
					f.pin_reset = 1'b0;
					f.software_reset = 1'b0;
					f.idle = 1'b0;
					f.sleep = 1'b0;
				end else if (watchdog_timeout) begin
					f.watchdog_timeout = 1'b1;
					f.sleep = 1'b1;
				end else if (irq_wake && in_sleep) begin
					f.sleep = 1'b1;
				end
				if (trap_conflict_evt)
					f.trap_conflict = 1'b1;
				if (illegal_op_evt)
					f.illegal_op = 1'b1;
			end
			reset_cause_reg <= f;
		end
	end

	property p_por_flags;
		@(posedge core_clk) disable iff (sys_rst)
		power_on_evt |=> reset_cause_reg.power_on && reset_cause_reg.brownout
			&& !reset_cause_reg.pin_reset && !reset_cause_reg.sleep;
	endproperty
	a_por_flags: assert property (p_por_flags)
		else $error("power-on flags wrong");

	property p_bor_flags;
		@(posedge core_clk) disable iff (sys_rst)
		bo_evt && !power_on_evt |=> reset_cause_reg.brownout
			&& !reset_cause_reg.power_on;
	endproperty
	a_bor_flags: assert property (p_bor_flags)
		else $error("brown-out flags wrong");

	property p_sw_flags;
		@(posedge core_clk) disable iff (sys_rst)
		sw_reset_evt && !power_on_evt && !bo_evt && !master_clear_pin
			|=> reset_cause_reg.software_reset && !reset_cause_reg.pin_reset;
	endproperty
	a_sw_flags: assert property (p_sw_flags)
		else $error("software reset flags wrong");

	property p_wdt_wake_pc;
		@(posedge core_clk) disable iff (sys_rst)
		watchdog_timeout && in_sleep && !any_reset
			|=> pc_load && pc_value == $past(cur_pc) + PC_STEP;
	endproperty
	a_wdt_wake_pc: assert property (p_wdt_wake_pc)
		else $error("watchdog wake vector wrong");

	property p_held_in_reset;
		@(posedge core_clk) disable iff (sys_rst)
		any_reset |=> internal_system_reset ##1 internal_system_reset;
	endproperty
	a_held_in_reset: assert property (p_held_in_reset)
		else $error("reset released too early");

	property p_frozen;
		@(posedge core_clk) disable iff (sys_rst)
		state_ff == ST_CLKWAIT && !clk_ready && !any_reset
			|=> internal_system_reset;
	endproperty
	a_frozen: assert property (p_frozen)
		else $error("left reset without a clock");

	property p_release_q1;
		@(posedge core_clk) disable iff (sys_rst)
		$fell(internal_system_reset) |-> $past(first_quarter_phase);
	endproperty
	a_release_q1: assert property (p_release_q1)
		else $error("release not on first quarter phase");

	property p_trap_vec;
		@(posedge core_clk) disable iff (sys_rst)
		clk_fail_trap |-> pc_load && pc_value == VEC_TRAP
			&& osc_group_sel == OSC_GRP_FAST_INT;
	endproperty
	a_trap_vec: assert property (p_trap_vec)
		else $error("clock trap vector or osc wrong");

	property p_trap_flag;
		@(posedge core_clk) disable iff (sys_rst)
		trap_conflict_evt && !power_on_evt |=> reset_cause_reg.trap_conflict;
	endproperty
	a_trap_flag: assert property (p_trap_flag)
		else $error("trap conflict flag not set");

	c_por_release: cover property (@(posedge core_clk) disable iff (sys_rst)
		power_on_evt ##[1:1000] $fell(internal_system_reset));
	c_clk_trap: cover property (@(posedge core_clk) disable iff (sys_rst)
		clk_fail_trap);
	c_irq_wake: cover property (@(posedge core_clk) disable iff (sys_rst)
		irq_wake && in_sleep && !any_reset);
endmodule // reset_cause_and_release_sequencer
`default_nettype wire

// File: testbench/reset_cause_and_release_sequencer_tb_top.sv
/*
 * self-checking bench for the reset cause and release sequencer.
 * assumes rst_seq_pkg and the design file are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none
module reset_cause_and_release_sequencer_tb_top;
	import rst_seq_pkg::*;
	// short delays keep the run brief; expectations derive from them
	localparam int B = 5, M = 8, P4 = 10, P16 = 20, P64 = 30;
	logic         core_clk = 1'b0;
	logic         sys_rst = 1'b1;
	cfg_fuses_t   cfg;
	cause_flags_t flags_wdata, flags;
	logic [8:0]   evt;
	logic         brownout_en, in_sleep, in_idle, osc_running, ost_done, q1;
	logic [23:0]  irq_vector, cur_pc, pcv;
	logic [15:0]  osc_ctl;
	logic         rst_o, trap_o, fast_o, pcl, bad;
	logic [1:0]   grp_o;
	int           n_mismatch = 0, check_count = 0, cyc = 0, n;

	always #5 core_clk = ~core_clk;

	reset_cause_and_release_sequencer #(
		.BIAS_CYC (B),
		.MON_CYC  (M),
		.PWR4_CYC (P4),
		.PWR16_CYC(P16),
		.PWR64_CYC(P64)
	) u_reset_cause_and_release_sequencer (
		.core_clk              (core_clk),
		.sys_rst               (sys_rst),
		.cfg                   (cfg),
		.power_on_evt          (evt[0]),
		.brownout_trip         (evt[1]),
		.brownout_en           (brownout_en),
		.master_clear_pin      (evt[2]),
		.sw_reset_evt          (evt[3]),
		.watchdog_timeout      (evt[4]),
		.trap_conflict_evt     (evt[5]),
		.illegal_op_evt        (evt[6]),
		.irq_wake              (evt[7]),
		.irq_vector            (irq_vector),
		.cur_pc                (cur_pc),
		.in_sleep              (in_sleep),
		.in_idle               (in_idle),
		.osc_running           (osc_running),
		.osc_startup_timer_done(ost_done),
		.osc_control_reg       (osc_ctl),
		.first_quarter_phase   (q1),
		.flags_wr              (evt[8]),
		.flags_wdata           (flags_wdata),
		.internal_system_reset (rst_o),
		.clk_fail_trap         (trap_o),
		.sel_fast_internal_osc (fast_o),
		.osc_group_sel         (grp_o),
		.pc_load               (pcl),
		.pc_value              (pcv),
		.reset_cause_reg       (flags),
		.bo_level_bad          (bad)
	);

	task automatic stop_test;
		if (n_mismatch == 0 && check_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_mismatch++;
			stop_test();
		end
	end

	task automatic chk(input string nm, input logic [23:0] e,
			input logic [23:0] g);
		check_count++;
		if (g !== e) begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic chkr(input string nm, input int v, input int lo,
			input int hi);
		check_count++;
		if (v < lo || v > hi) begin
			n_mismatch++;
			$display("ERROR %s expected %0d..%0d seen %0d", nm, lo, hi, v);
		end
	endtask

	// waits a cycle first so a strobe is never set where it was cleared
	task automatic ev(input int k);
		@(negedge core_clk);
		evt[k] = 1'b1;
		@(negedge core_clk);
		evt = '0;
	endtask

	task automatic wr(input logic [8:0] f);
		flags_wdata = f;
		ev(8);
		chk("flags_rd", f, flags);
	endtask

	task automatic wait_rel(input logic [23:0] pc, output int c);
		c = 0;
		while (rst_o !== 1'b0 && c < 300) begin
			@(negedge core_clk);
			c++;
		end
		chk("rel_pc_load", 1'b1, pcl);
		chk("rel_pc_value", pc, pcv);
	endtask

	task automatic t_power_up;
		int d[4];
		d = '{0, P4, P16, P64};
		for (int k = 0; k < 4; k++) begin
			wr(9'h1FF);
			cfg.power_up_timer = k[1:0];
			ev(0);
			chk("por_flags", 9'h003, flags);
			wait_rel(VEC_RESET, n);
			chkr("por_delay", n, B + d[k] + 1, B + d[k] + 3);
		end
		cfg.power_up_timer = PWRUP_NONE;
	endtask

	task automatic t_trap;
		cfg.clock_fail_monitor = 1'b1;
		osc_running = 1'b0;
		wr(9'h0F0);
		ev(1);
		wait_rel(VEC_TRAP, n);
		chk("trap_pulse", 1'b1, trap_o);
		chk("fast_osc", 1'b1, fast_o);
		chk("trap_grp", OSC_GRP_FAST_INT, grp_o);
		chk("trap_flags", 9'h0F2, flags);
		cfg.clock_fail_monitor = 1'b0;
		osc_running = 1'b1;
	endtask

	task automatic t_bor;
		in_sleep = 1'b1;
		wr(9'h1FF);
		ev(1);
		chk("bor_flags", 9'h1FE, flags);
		in_sleep = 1'b0;
		wait_rel(VEC_RESET, n);
		chk("bor_grp", 2'h1, grp_o);
		brownout_en = 1'b0;
		wr(9'h000);
		ev(1);
		chk("bor_off_flags", 9'h000, flags);
		chk("bor_off_rst", 1'b0, rst_o);
		brownout_en = 1'b1;
		cfg.crystal_mode = 1'b1;
		ev(1);
		wait_rel(VEC_RESET, n);
		chkr("mon_delay", n, B + M + 1, B + M + 3);
		cfg.crystal_mode = 1'b0;
	endtask

	// pin normal, pin in sleep, pin in idle, software, watchdog, traps
	task automatic t_resets;
		int         ek[7];
		logic [8:0] pre[7];
		logic [8:0] ex[7];
		ek = '{2, 2, 2, 3, 4, 5, 6};
		pre = '{9'h1FF, 9'h1FF, 9'h1FF, 9'h1FF, 9'h1FF, 9'h0AA, 9'h155};
		ex = '{9'h1C3, 9'h1C7, 9'h1CB, 9'h1A3, 9'h193, 9'h1AA, 9'h1D5};
		for (int i = 0; i < 7; i++) begin
			wr(pre[i]);
			in_sleep = (i == 1);
			in_idle = (i == 2);
			ev(ek[i]);
			in_sleep = 1'b0;
			in_idle = 1'b0;
			chk("cause_flags", ex[i], flags);
			wait_rel(VEC_RESET, n);
		end
	endtask

	task automatic t_wake;
		cur_pc = 24'h000100;
		irq_vector = 24'h000040;
		for (int i = 0; i < 2; i++) begin
			in_sleep = 1'b1;
			wr(9'h000);
			ev(i == 0 ? 4 : 7);
			chk("wake_pc_load", 1'b1, pcl);
			chk("wake_pc", i == 0 ? 24'h000102 : 24'h000040, pcv);
			chk("wake_flags", i == 0 ? 9'h014 : 9'h004, flags);
			chk("wake_rst", 1'b0, rst_o);
			in_sleep = 1'b0;
		end
	endtask

	// each pass withholds one release condition, then grants it
	task automatic t_hold;
		for (int k = 0; k < 4; k++) begin
			case (k)
				0: osc_running = 1'b0;
				1: begin
					cfg.crystal_mode = 1'b1;
					ost_done = 1'b0;
				end
				2: begin
					cfg.pll_used = 1'b1;
					osc_ctl[OSC_LOCK_BIT] = 1'b0;
				end
				default: q1 = 1'b0;
			endcase
			ev(k == 0 ? 3 : 1);
			repeat (40) @(negedge core_clk);
			chk("held_rst", 1'b1, rst_o);
			osc_running = 1'b1;
			ost_done = 1'b1;
			osc_ctl[OSC_LOCK_BIT] = 1'b1;
			q1 = 1'b1;
			wait_rel(VEC_RESET, n);
			chkr("late_release", n, 0, 3);
		end
		cfg.pll_used = 1'b0;
		cfg.crystal_mode = 1'b0;
	endtask

	task automatic t_level;
		for (int k = 0; k < 4; k++) begin
			cfg.bo_level = k[1:0];
			repeat (2) @(negedge core_clk);
			chk("bo_level_bad", k == 3, bad);
		end
		cfg.bo_level = BO_LVL_LOW;
	endtask

	initial begin
		cfg = '0;
		cfg.osc_group_fuse = 2'h1;
		flags_wdata = '0;
		evt = '0;
		brownout_en = 1'b1;
		in_sleep = 1'b0;
		in_idle = 1'b0;
		osc_running = 1'b1;
		ost_done = 1'b1;
		q1 = 1'b1;
		irq_vector = 24'h000000;
		cur_pc = 24'h000000;
		osc_ctl = 16'h0020;
		repeat (2) @(negedge core_clk);
		sys_rst = 1'b0;
		wait_rel(VEC_RESET, n);
		chk("rst_flags", 9'h000, flags);
		t_power_up();
		t_trap();
		t_bor();
		t_resets();
		t_wake();
		t_hold();
		t_level();
		stop_test();
	end
endmodule // reset_cause_and_release_sequencer_tb_top
`default_nettype wire
